//--- core/dcs_channel_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcs_defines.svh"

// Operation
// R1: Bit 31 reads 1 while the channel is ready, else 0; resets to 0.
// R2: Normal termination sets the normal-done flag, bit 23.
// R3: Normal-done with its interrupt enabled raises a request.
// R4: Writing 0 clears normal-done; its request drops once the flag is 0.
// R5: Writing 1 to either completion flag leaves it unchanged.
// R6: Start while normal-done is set is an error, no transfer starts.
// R7: Software clears normal-done before the next start.
// R8: Abnormal termination sets bit 22 and requests an enabled interrupt.
// R9: Writing 0 clears abnormal-done; its request is cancelled then.
// R10: Clearing abnormal-done also clears the three error flags.
// R11: Start while abnormal-done is set is an error; software clears it first.
// R12: Source bus error sets read-only bit 20.
// R13: Destination bus error sets read-only bit 19.
// R14: Configuration error sets read-only bit 18.
// R15: Software writes 0 to reserved bits 21 and 2:0.
// R16: Any error flag set also ends the channel and sets abnormal-done.
module dcs_channel_status
  import dcs_pkg::*;
(
  input  wire logic        mclk,         // System clock, 200 MHz
  input  wire logic        resetn,       // Asynchronous reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB access phase
  input  wire logic        pwrite,       // APB write
  input  wire logic [11:0] paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  input  wire logic [3:0]  pstrb,        // APB byte strobes
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error, unmapped address
  input  wire logic        chanReady,    // Engine: channel in ready state
  input  wire logic        normalDone,   // Engine: normal termination pulse
  input  wire logic        abnormalDone, // Engine: abnormal termination pulse
  input  wire logic        srcBusErr,    // Engine: source bus error pulse
  input  wire logic        dstBusErr,    // Engine: destination bus error pulse
  input  wire logic        cfgErr,       // Engine: configuration error pulse
  output logic             startReq,     // To engine: start transfer pulse
  output logic             abortReq,     // To engine: end channel pulse
  output logic             startErr,     // Refused start pulse
  output logic             ncIrqReq,     // Normal-completion request level
  output logic             abnIrqReq,    // Abnormal-completion request level
  output logic             irq           // Combined masked interrupt level
);

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        pready_q;
  dcs_word_t   prdata_q;
  logic        pslverr_q;
  dcs_sel_t    sel;
  logic        wrAcc;
  logic        stWr;
  logic        ctWr;
  logic        clrNc;
  logic        clrAbn;
  logic        startTry;
  logic        anyErr;
  logic        abnSet;
  logic        actFlag_q;
  logic        ncFlag_q;
  logic        abnFlag_q;
  logic        srcErrFlag_q;
  logic        dstErrFlag_q;
  logic        confFlag_q;
  logic        ncIe_q;
  logic        abnIe_q;
  logic        startReq_q;
  logic        abortReq_q;
  logic        startErr_q;
  logic        ncIrqReq_q;
  logic        abnIrqReq_q;
  logic        irq_q;
  logic [`DCS_IS_W-1:0] irqStat_q;
  logic [`DCS_IS_W-1:0] irqMask_q;
  logic [`DCS_IS_W-1:0] irqEvt;
  dcs_word_t   rdWord;

  // Address to register select; anything else answers with an error
  always_comb begin
    unique case (paddr)
      `DCS_OFS_STATUS:  sel = DCS_SEL_STATUS;
      `DCS_OFS_CONTROL: sel = DCS_SEL_CONTROL;
      `DCS_OFS_IRQSTAT: sel = DCS_SEL_IRQSTAT;
      `DCS_OFS_IRQMASK: sel = DCS_SEL_IRQMASK;
      default:          sel = DCS_SEL_NONE;
    endcase
  end

  // A write lands only at the edge that completes the access phase
  assign wrAcc    = psel & penable & pready_q & pwrite;
  assign stWr     = wrAcc & (sel == DCS_SEL_STATUS) & pstrb[2];
  assign ctWr     = wrAcc & (sel == DCS_SEL_CONTROL) & pstrb[0];
  assign clrNc    = stWr & ~pwdata[`DCS_ST_NC];  // R4
  assign clrAbn   = stWr & ~pwdata[`DCS_ST_ABN]; // R9
  assign startTry = ctWr & pwdata[`DCS_CT_START];
  assign anyErr   = srcBusErr | dstBusErr | cfgErr;
  assign abnSet   = abnormalDone | anyErr;       // R16

  // Read mux; reserved bits read as zero whatever software wrote
  always_comb begin
    rdWord = `DCS_RST_WORD;
    unique case (sel)
      DCS_SEL_STATUS: begin
        rdWord[`DCS_ST_ACT]  = actFlag_q; // R1
        rdWord[`DCS_ST_NC]   = ncFlag_q;
        rdWord[`DCS_ST_ABN]    = abnFlag_q;
        rdWord[`DCS_ST_SRCERR] = srcErrFlag_q;
        rdWord[`DCS_ST_DSTERR] = dstErrFlag_q;
        rdWord[`DCS_ST_CONF]   = confFlag_q;
      end
      DCS_SEL_CONTROL: begin
        rdWord[`DCS_CT_NCIE]  = ncIe_q;
        rdWord[`DCS_CT_ABNIE] = abnIe_q;
      end
      DCS_SEL_IRQSTAT: rdWord[`DCS_IS_W-1:0] = irqStat_q;
      DCS_SEL_IRQMASK: rdWord[`DCS_IS_W-1:0] = irqMask_q;
      DCS_SEL_NONE:    rdWord = `DCS_RST_WORD;
    endcase
  end

  // One wait-free access phase: ready rises in the cycle after setup
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= `DCS_RST_WORD;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & (sel == DCS_SEL_NONE);
      if (psel & ~penable & ~pwrite) begin
        prdata_q <= rdWord;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel status flags

  // Ready mirror; engine is on this clock so no synchroniser is needed
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      actFlag_q <= 1'b0;
    end else begin
      actFlag_q <= chanReady; // R1
    end
  end

  // Completion flags: engine sets, software writes 0 to clear.
  // A set in the same cycle as the clear wins so no termination is lost.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ncFlag_q  <= 1'b0;
      abnFlag_q <= 1'b0;
    end else begin
      ncFlag_q  <= normalDone | (ncFlag_q & ~clrNc); // R2 R4 R5
      abnFlag_q <= abnSet | (abnFlag_q & ~clrAbn);   // R8 R9 R5 R16
    end
  end

  // Error causes are read-only and fall together with abnormal-done
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      srcErrFlag_q <= 1'b0;
      dstErrFlag_q <= 1'b0;
      confFlag_q   <= 1'b0;
    end else begin
      srcErrFlag_q <= srcBusErr | (srcErrFlag_q & ~clrAbn); // R12 R10
      dstErrFlag_q <= dstBusErr | (dstErrFlag_q & ~clrAbn); // R13 R10
      confFlag_q   <= cfgErr | (confFlag_q & ~clrAbn);      // R14 R10
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control and start

  // Interrupt enables live in the control word
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ncIe_q  <= 1'b0;
      abnIe_q <= 1'b0;
    end else if (ctWr) begin
      ncIe_q  <= pwdata[`DCS_CT_NCIE];
      abnIe_q <= pwdata[`DCS_CT_ABNIE];
    end
  end

  // Start is refused while a completion is still pending, since the
  // engine would otherwise overwrite a result software has not seen
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      startReq_q <= 1'b0;
      startErr_q <= 1'b0;
      abortReq_q <= 1'b0;
    end else begin
      startReq_q <= startTry & ~ncFlag_q & ~abnFlag_q; // R6 R11
      startErr_q <= startTry & (ncFlag_q | abnFlag_q); // R6 R11
      abortReq_q <= anyErr;                            // R16
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Per-flag requests follow the flags, so a cleared flag drops its line
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ncIrqReq_q  <= 1'b0;
      abnIrqReq_q <= 1'b0;
    end else begin
      ncIrqReq_q  <= ncFlag_q & ncIe_q;   // R3 R4
      abnIrqReq_q <= abnFlag_q & abnIe_q; // R8 R9
    end
  end

  assign irqEvt[`DCS_IS_NC]    = normalDone;
  assign irqEvt[`DCS_IS_ABN]   = abnSet;
  assign irqEvt[`DCS_IS_STERR] = startTry & (ncFlag_q | abnFlag_q);

  // Sticky event bits, write 1 to clear; a new event beats the clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irqStat_q <= `DCS_RST_IRQ;
      irqMask_q <= `DCS_RST_IRQ;
    end else begin
      if (wrAcc & (sel == DCS_SEL_IRQSTAT) & pstrb[0]) begin
        irqStat_q <= irqEvt | (irqStat_q & ~pwdata[`DCS_IS_W-1:0]);
      end else begin
        irqStat_q <= irqEvt | irqStat_q;
      end
      if (wrAcc & (sel == DCS_SEL_IRQMASK) & pstrb[0]) begin
        irqMask_q <= pwdata[`DCS_IS_W-1:0];
      end
    end
  end

  // Combined line is one cycle behind the sticky bits
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irqStat_q & irqMask_q);
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign startReq  = startReq_q;
  assign abortReq  = abortReq_q;
  assign startErr  = startErr_q;
  assign ncIrqReq  = ncIrqReq_q;
  assign abnIrqReq = abnIrqReq_q;
  assign irq       = irq_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence ncGone;
    !ncFlag_q ##1 !ncIrqReq_q;
  endsequence

  sequence abnGone;
    !abnFlag_q && !srcErrFlag_q && !dstErrFlag_q && !confFlag_q ##1 !abnIrqReq_q;
  endsequence

  sequence refused;
    !startReq_q && startErr_q ##1 irqStat_q[`DCS_IS_STERR];
  endsequence

  AST_ACT_MIRROR: assert property (chanReady |=> actFlag_q) // R1
    else $error("Active flag does not follow channel ready");
  AST_NC_SET: assert property (normalDone |=> ncFlag_q) // R2
    else $error("Normal-done not set on normal termination");
  AST_NC_IRQ: assert property (normalDone && ncIe_q && !ctWr |=> ##1 ncIrqReq_q) // R3
    else $error("Normal-completion request not raised");
  AST_NC_CLR: assert property (clrNc && !normalDone |=> ncGone) // R4
    else $error("Normal-done clear did not drop flag and request");
  AST_W1_NOEFFECT: assert property (stWr && pwdata[`DCS_ST_NC] && pwdata[`DCS_ST_ABN] // R5
    |=> ncFlag_q == ($past(ncFlag_q) || $past(normalDone))
        && abnFlag_q == ($past(abnFlag_q) || $past(abnSet)))
    else $error("Writing one changed a completion flag");
  AST_START_REFUSE: assert property (startTry && (ncFlag_q || abnFlag_q) |=> refused) // R6 R11
    else $error("Start with pending completion was not refused");
  AST_ABN_SET: assert property (abnormalDone && abnIe_q && !ctWr // R8
    |=> abnFlag_q ##1 abnIrqReq_q)
    else $error("Abnormal-done or its request not raised");
  AST_ABN_CLR: assert property (clrAbn && !abnSet |=> abnGone) // R9 R10
    else $error("Abnormal-done clear left flags or request");
  AST_ERR_FLAGS: assert property (anyErr |=> (srcErrFlag_q || !$past(srcBusErr)) // R12 R13 R14
    && (dstErrFlag_q || !$past(dstBusErr)) && (confFlag_q || !$past(cfgErr)))
    else $error("Error cause flag not recorded");
  AST_ERR_ABORT: assert property (anyErr |=> abnFlag_q && abortReq_q) // R16
    else $error("Error did not end channel with abnormal-done");
  AST_START_OK: assert property (startTry && !ncFlag_q && !abnFlag_q // R6
    |=> startReq_q && !startErr_q)
    else $error("Clean start did not reach the engine");

endmodule
`default_nettype wire

//--- core/dcs_defines.svh
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH

// Register byte offsets
`define DCS_OFS_STATUS   12'h000
`define DCS_OFS_CONTROL  12'h004
`define DCS_OFS_IRQSTAT  12'h008
`define DCS_OFS_IRQMASK  12'h00C

// Channel status field positions
`define DCS_ST_ACT       31
`define DCS_ST_NC        23
`define DCS_ST_ABN       22
`define DCS_ST_SRCERR    20
`define DCS_ST_DSTERR    19
`define DCS_ST_CONF      18

// Channel control field positions
`define DCS_CT_START     0
`define DCS_CT_NCIE      1
`define DCS_CT_ABNIE     2

// Interrupt status / mask field positions
`define DCS_IS_NC        0
`define DCS_IS_ABN       1
`define DCS_IS_STERR     2
`define DCS_IS_W         3

// Reset values
`define DCS_RST_WORD     32'h0000_0000
`define DCS_RST_IRQ      3'h0

`endif

//--- core/dcs_pkg.sv
`default_nettype none
package dcs_pkg;
  typedef logic [31:0] dcs_word_t;
  typedef enum {
    DCS_SEL_STATUS,
    DCS_SEL_CONTROL,
    DCS_SEL_IRQSTAT,
    DCS_SEL_IRQMASK,
    DCS_SEL_NONE
  } dcs_sel_t;
endpackage
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcs_defines.svh"

module tb_top
  import dcs_pkg::*;
;
  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  dcs_word_t   pwdata, prdata;
  logic [3:0]  pstrb;
  logic        chanReady, normalDone, abnormalDone, srcBusErr, dstBusErr, cfgErr;
  logic        startReq, abortReq, startErr, ncIrqReq, abnIrqReq, irq;
  int          err_total, n_tests, i;
  logic [32:0] rdQ[$];
  logic [1:0]  startQ[$];
  logic [31:0] lfsr;
  logic [2:0]  m;

  dcs_channel_status i_dcs_channel_status (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chanReady(chanReady), .normalDone(normalDone),
    .abnormalDone(abnormalDone), .srcBusErr(srcBusErr), .dstBusErr(dstBusErr),
    .cfgErr(cfgErr), .startReq(startReq), .abortReq(abortReq), .startErr(startErr),
    .ncIrqReq(ncIrqReq), .abnIrqReq(abnIrqReq), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 5 ns period
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Pseudo-random source for mask values
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // APB master: request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 16) begin
      err_total++;
      $display("MISMATCH at %0t: pready never came", $time);
      print_verdict();
    end
  endtask

  // Read notes {pslverr, prdata} before the transfer goes out
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rdQ.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // One-cycle engine event; errors must pulse the channel end request
  task automatic pulse(input int k);
    @(posedge mclk);
    case (k)
      0: normalDone <= 1'b1;
      1: abnormalDone <= 1'b1;
      2: srcBusErr <= 1'b1;
      3: dstBusErr <= 1'b1;
      default: cfgErr <= 1'b1;
    endcase
    @(posedge mclk);
    {normalDone, abnormalDone, srcBusErr, dstBusErr, cfgErr} <= 5'h00;
    #1;
    if (k > 1) chk({32'h0, abortReq}, 33'h1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: each result takes the oldest note off its queue
  always @(posedge mclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      chk({pslverr, prdata}, rdQ.pop_front());
    end
    if (startReq === 1'b1 || startErr === 1'b1) begin
      chk({31'h0, startReq, startErr}, {31'h0, startQ.pop_front()});
    end
  end

  // Hang guard
  initial begin
    #200000;
    err_total++;
    $display("MISMATCH at %0t: run timed out", $time);
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, chanReady} = 4'h0;
    {normalDone, abnormalDone, srcBusErr, dstBusErr, cfgErr} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    resetn = 1'b0;
    err_total = 0;
    n_tests = 0;
    lfsr = 32'h0000_152D;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rd(`DCS_OFS_STATUS, 33'h0);
    rd(`DCS_OFS_CONTROL, 33'h0);
    rd(`DCS_OFS_IRQSTAT, 33'h0);
    rd(12'h010, {1'b1, 32'h0});
    chanReady <= 1'b1;
    rd(`DCS_OFS_STATUS, 33'h0_8000_0000);
    chanReady <= 1'b0;
    rd(`DCS_OFS_STATUS, 33'h0);
    $display("Test reset and ready flag done");
    // Normal completion with its request enabled
    apb(1'b1, `DCS_OFS_CONTROL, 32'h0000_0002);
    pulse(0);
    rd(`DCS_OFS_STATUS, 33'h0_0080_0000);
    chk({32'h0, ncIrqReq}, 33'h1);
    apb(1'b1, `DCS_OFS_STATUS, 32'hFFDF_FFF8);
    rd(`DCS_OFS_STATUS, 33'h0_0080_0000);
    startQ.push_back(2'b01);
    apb(1'b1, `DCS_OFS_CONTROL, 32'h0000_0003);
    // A clear that misses the flag byte's strobe must leave the flag set
    pstrb <= 4'hB;
    apb(1'b1, `DCS_OFS_STATUS, 32'h0000_0000);
    pstrb <= 4'hF;
    rd(`DCS_OFS_STATUS, 33'h0_0080_0000);
    apb(1'b1, `DCS_OFS_STATUS, 32'h0000_0000);
    rd(`DCS_OFS_STATUS, 33'h0);
    chk({32'h0, ncIrqReq}, 33'h0);
    startQ.push_back(2'b10);
    apb(1'b1, `DCS_OFS_CONTROL, 32'h0000_0003);
    $display("Test normal completion done");
    // Each error cause, a refused start, then one clearing write
    apb(1'b1, `DCS_OFS_CONTROL, 32'h0000_0004);
    for (i = 2; i < 5; i++) begin
      pulse(i);
      rd(`DCS_OFS_STATUS, {1'b0, 32'h0040_0000 | (32'h0010_0000 >> (i - 2))});
      chk({32'h0, abnIrqReq}, 33'h1);
      startQ.push_back(2'b01);
      apb(1'b1, `DCS_OFS_CONTROL, 32'h0000_0005);
      apb(1'b1, `DCS_OFS_STATUS, 32'h0080_0000);
      rd(`DCS_OFS_STATUS, 33'h0);
      chk({32'h0, abnIrqReq}, 33'h0);
    end
    pulse(1);
    rd(`DCS_OFS_STATUS, 33'h0_0040_0000);
    apb(1'b1, `DCS_OFS_STATUS, 32'h0000_0000);
    $display("Test abnormal completion done");
    // Sticky events, masking and write-one-to-clear
    apb(1'b1, `DCS_OFS_IRQSTAT, 32'h0000_0007);
    rd(`DCS_OFS_IRQSTAT, 33'h0);
    for (i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      m = (i == 0) ? 3'h7 : lfsr[2:0];
      apb(1'b1, `DCS_OFS_IRQMASK, {29'h0, m});
      rd(`DCS_OFS_IRQMASK, {30'h0, m});
      // All three event kinds, so every mask bit matters to the line
      pulse(0);
      pulse(1);
      startQ.push_back(2'b01);
      apb(1'b1, `DCS_OFS_CONTROL, 32'h0000_0001);
      repeat (2) @(posedge mclk);
      #1;
      chk({32'h0, irq}, {32'h0, |m});
      rd(`DCS_OFS_IRQSTAT, 33'h7);
      apb(1'b1, `DCS_OFS_IRQSTAT, 32'h0000_0007);
      repeat (2) @(posedge mclk);
      #1;
      chk({32'h0, irq}, 33'h0);
      apb(1'b1, `DCS_OFS_STATUS, 32'h0000_0000);
    end
    $display("Test interrupt mask done");
    repeat (4) @(posedge mclk);
    // A start result or read that never came leaves its note behind
    chk({32'h0, (startQ.size() == 0) && (rdQ.size() == 0)}, 33'h1);
    print_verdict();
  end
endmodule

`default_nettype wire
